//--- rtl/qrps_cfg.svh
// Purpose: Constants of the quad rail power sequencer.
// Assumes: Included by the package and by every design file but the rail interface.
// Notes: Times are in milliseconds; cycle counts derive from the clock rate.
`ifndef QRPS_CFG_SVH
`define QRPS_CFG_SVH

// ********************************************************
// Clock and time base
// ********************************************************
`define QRPS_CLK_HZ 10000000
`define QRPS_MS_PER_S 1000
`define QRPS_MS_CYCLES (`QRPS_CLK_HZ / `QRPS_MS_PER_S)

// ********************************************************
// Sequencing times, milliseconds
// ********************************************************
`define QRPS_SOFT_START_MS 4
`define QRPS_TIME_SEQ_DELAY_MS 2
`define QRPS_GOOD_SEQ_DELAY_MS 6
`define QRPS_MS_CNT_W 4

// ********************************************************
// Rails and pin vector layout
// ********************************************************
`define QRPS_RAILS 4
`define QRPS_PIN_W 14
`define QRPS_PIN_DELAY_MODE 13
`define QRPS_PIN_ORDER_HI 12
`define QRPS_PIN_SEQ_RUN 9
`define QRPS_PIN_OVER_TEMP 8
`define QRPS_PIN_START_HI 7
`define QRPS_PIN_THRESH_HI 3
// Delay mode and order bits idle high, as their pull-ups make them
`define QRPS_PIN_RESET 14'h3C00

// ********************************************************
// Rail order per order-select code, {pos3,pos2,pos1,pos0}, rail index 0..3
// ********************************************************
`define QRPS_ORDER_0 8'h1B
`define QRPS_ORDER_1 8'h4B
`define QRPS_ORDER_2 8'h1E
`define QRPS_ORDER_3 8'h4E
`define QRPS_ORDER_4 8'hB1
`define QRPS_ORDER_5 8'hB4
`define QRPS_ORDER_6 8'hE1
`define QRPS_ORDER_7 8'hE4

`endif

//--- rtl/qrps_ms_tick.sv
// Purpose: Millisecond time base enable.
// Assumes: Single clock domain.
// Notes: Pulse is one cycle wide every CYCLES clocks.
`timescale 1ns/1ns
`include "qrps_cfg.svh"
module qrps_ms_tick
	import qrps_pkg::*;
#(
	parameter int CYCLES = `QRPS_MS_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	output logic msTick
);
	localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

	logic [CW-1:0] divCount;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			divCount <= '0;
			msTick <= 1'b0;
		end else if (divCount == CW'(CYCLES - 1)) begin
			divCount <= '0;
			msTick <= 1'b1;
		end else begin
			divCount <= divCount + CW'(1);
			msTick <= 1'b0;
		end
	end
endmodule

//--- rtl/qrps_pkg.sv
// Purpose: Types of the quad rail power sequencer.
// Assumes: Constants come from qrps_cfg.svh.
// Notes: None.
`include "qrps_cfg.svh"
package qrps_pkg;

	typedef logic [`QRPS_MS_CNT_W-1:0] qrps_ms_t;
	typedef logic [1:0] qrps_pos_t;

	typedef enum logic [3:0] {
		SEQ_IDLE,
		SEQ_STEP_ON,
		SEQ_SOFT_WAIT,
		SEQ_GOOD_WAIT,
		SEQ_STEP_DELAY,
		SEQ_ALL_ON,
		SEQ_STEP_OFF,
		SEQ_OFF_DELAY,
		SEQ_SHUTDOWN
	} qrps_state_e;

endpackage

//--- rtl/qrps_rail_ctrl.sv
// Purpose: Soft start timing and rail-good for one regulator.
// Assumes: Start request and threshold inputs already synchronised.
// Notes: Ramp enable drops at once on shutdown.
`timescale 1ns/1ns
`include "qrps_cfg.svh"
module qrps_rail_ctrl
	import qrps_pkg::*;
#(
	parameter int SOFT_START_MS = `QRPS_SOFT_START_MS
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic msTick,
	input wire logic shutdown,
	input wire logic timeMode,
	qrps_rail_if.rail bus
);
	localparam qrps_ms_t SS_LAST = qrps_ms_t'(SOFT_START_MS - 1);

	qrps_ms_t ssCount;
	logic ssDone;

	// ********************************************************
	// Ramp enable
	// ********************************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.rampEnable <= 1'b0;
		end else begin
			bus.rampEnable <= bus.startRequest & ~shutdown;
		end
	end

	// ********************************************************
	// Soft start timer
	// ********************************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ssCount <= '0;
			ssDone <= 1'b0;
		end else if (!bus.rampEnable) begin
			ssCount <= '0;
			ssDone <= 1'b0;
		end else if (msTick && !ssDone) begin
			if (ssCount == SS_LAST) begin
				ssDone <= 1'b1;
			end else begin
				ssCount <= ssCount + qrps_ms_t'(1);
			end
		end
	end

	// ********************************************************
	// Rail good
	// ********************************************************
	// Delay mode has no threshold to trust, so soft start end stands in
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.railGood <= 1'b0;
		end else begin
			bus.railGood <= bus.rampEnable & bus.startRequest & ~shutdown
				& (timeMode ? ssDone : bus.atThreshold);
		end
	end
endmodule

//--- rtl/qrps_rail_if.sv
// Purpose: Signals between the sequencer core and one rail controller.
// Assumes: One instance per rail.
// Notes: None.
`timescale 1ns/1ns
interface qrps_rail_if;
	logic startRequest;
	logic atThreshold;
	logic rampEnable;
	logic railGood;

	modport rail (
		input startRequest,
		input atThreshold,
		output rampEnable,
		output railGood
	);

	modport seq (
		output startRequest,
		output atThreshold,
		input rampEnable,
		input railGood
	);
endinterface

//--- rtl/qrps_top.sv
// Purpose: Four-rail power sequencer with delay and power-good modes.
// Assumes: Pins are asynchronous; threshold inputs come from regulator comparators.
// Notes: Step drives are wired to start requests on the board.
`timescale 1ns/1ns
`include "qrps_cfg.svh"
module qrps_top
	import qrps_pkg::*;
#(
	parameter int CYCLES_PER_MS = `QRPS_MS_CYCLES,
	parameter int SOFT_START_MS = `QRPS_SOFT_START_MS,
	parameter int TIME_SEQ_DELAY_MS = `QRPS_TIME_SEQ_DELAY_MS,
	parameter int GOOD_SEQ_DELAY_MS = `QRPS_GOOD_SEQ_DELAY_MS
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic delayModeSelect,
	input wire logic seqRun,
	input wire logic overTemp,
	input wire logic orderSelectBit0,
	input wire logic orderSelectBit1,
	input wire logic orderSelectBit2,
	input wire logic rail1StartRequest,
	input wire logic rail2StartRequest,
	input wire logic rail3StartRequest,
	input wire logic rail4StartRequest,
	input wire logic [`QRPS_RAILS-1:0] railAtThreshold,
	output logic step1Drive,
	output logic step2Drive,
	output logic step3Drive,
	output logic step4Drive,
	output logic [`QRPS_RAILS-1:0] railRampEnable,
	output logic [`QRPS_RAILS-1:0] railGood,
	output logic globalRailGood,
	output logic thermalShutdown,
	output logic sequenceDone
);

	// ********************************************************
	// Constants
	// ********************************************************
	localparam qrps_ms_t SS_LAST = qrps_ms_t'(SOFT_START_MS - 1);
	localparam qrps_ms_t TIME_LAST = qrps_ms_t'(TIME_SEQ_DELAY_MS - 1);
	localparam qrps_ms_t GOOD_LAST = qrps_ms_t'(GOOD_SEQ_DELAY_MS - 1);
	localparam qrps_pos_t LAST_POS = qrps_pos_t'(`QRPS_RAILS - 1);

	// ********************************************************
	// Pin synchronisers
	// ********************************************************
	logic [`QRPS_PIN_W-1:0] pinRaw;
	logic [`QRPS_PIN_W-1:0] pinMeta;
	logic [`QRPS_PIN_W-1:0] pinSync;

	assign pinRaw = {delayModeSelect, orderSelectBit2, orderSelectBit1, orderSelectBit0,
		seqRun, overTemp,
		rail4StartRequest, rail3StartRequest, rail2StartRequest, rail1StartRequest,
		railAtThreshold};

	// Reset value mirrors the pull-ups so the first decisions see defaults
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pinMeta <= `QRPS_PIN_RESET;
			pinSync <= `QRPS_PIN_RESET;
		end else begin
			pinMeta <= pinRaw;
			pinSync <= pinMeta;
		end
	end

	logic timeMode;
	logic [2:0] orderCode;
	logic runLevel;
	logic hot;
	logic [`QRPS_RAILS-1:0] startReq;
	logic [`QRPS_RAILS-1:0] atThr;

	assign timeMode = pinSync[`QRPS_PIN_DELAY_MODE];
	assign orderCode = pinSync[`QRPS_PIN_ORDER_HI -: 3];
	assign runLevel = pinSync[`QRPS_PIN_SEQ_RUN];
	assign hot = pinSync[`QRPS_PIN_OVER_TEMP];
	assign startReq = pinSync[`QRPS_PIN_START_HI -: `QRPS_RAILS];
	assign atThr = pinSync[`QRPS_PIN_THRESH_HI -: `QRPS_RAILS];

	// ********************************************************
	// Time base
	// ********************************************************
	logic msTick;

	qrps_ms_tick #(
		.CYCLES(CYCLES_PER_MS)
	) u_tick (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.msTick(msTick)
	);

	// ********************************************************
	// Thermal latch
	// ********************************************************
	logic runPrev;
	logic runRise;
	logic shutLatch;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			runPrev <= 1'b0;
		end else begin
			runPrev <= runLevel;
		end
	end

	assign runRise = runLevel & ~runPrev;

	// Set wins over the restart edge; a still-hot die keeps rails off
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			shutLatch <= 1'b0;
		end else if (hot) begin
			shutLatch <= 1'b1;
		end else if (runRise) begin
			shutLatch <= 1'b0;
		end
	end

	assign thermalShutdown = shutLatch;

	// ********************************************************
	// Rail controllers
	// ********************************************************
	logic seqTimeMode;

	genvar gi;
	generate
		for (gi = 0; gi < `QRPS_RAILS; gi++) begin : g_rail
			qrps_rail_if railBus ();

			assign railBus.startRequest = startReq[gi];
			assign railBus.atThreshold = atThr[gi];
			assign railRampEnable[gi] = railBus.rampEnable;
			assign railGood[gi] = railBus.railGood;

			// Every rail on the same step sees the same drive edge
			qrps_rail_ctrl #(
				.SOFT_START_MS(SOFT_START_MS)
			) u_rail (
				.core_clk(core_clk),
				.rst_b(rst_b),
				.msTick(msTick),
				.shutdown(shutLatch | hot),
				.timeMode(seqTimeMode),
				.bus(railBus)
			);
		end
	endgenerate

	// ********************************************************
	// Step order
	// ********************************************************
	function automatic qrps_pos_t railOfPos(input logic [2:0] code, input qrps_pos_t pos);
		logic [7:0] ord;
		ord = `QRPS_ORDER_7;
		unique case (code)
			3'h0: ord = `QRPS_ORDER_0;
			3'h1: ord = `QRPS_ORDER_1;
			3'h2: ord = `QRPS_ORDER_2;
			3'h3: ord = `QRPS_ORDER_3;
			3'h4: ord = `QRPS_ORDER_4;
			3'h5: ord = `QRPS_ORDER_5;
			3'h6: ord = `QRPS_ORDER_6;
			3'h7: ord = `QRPS_ORDER_7;
		endcase
		return ord[{pos, 1'b0} +: 2];
	endfunction

	qrps_state_e state;
	qrps_pos_t pos;
	qrps_pos_t curStep;
	qrps_ms_t msCount;
	qrps_ms_t stepLast;
	logic [2:0] seqOrder;
	logic [`QRPS_RAILS-1:0] stepDrive;
	logic upPhase;

	// Delay mode steps through the drives in order; board wiring sets rails
	assign curStep = seqTimeMode ? pos : railOfPos(seqOrder, pos);
	assign stepLast = seqTimeMode ? TIME_LAST : GOOD_LAST;
	assign upPhase = (state == SEQ_STEP_ON) || (state == SEQ_SOFT_WAIT)
		|| (state == SEQ_GOOD_WAIT) || (state == SEQ_STEP_DELAY) || (state == SEQ_ALL_ON);

	// ********************************************************
	// Sequencer
	// ********************************************************
	// Mode and order are frozen per sequence so a strap change cannot skip rails
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			seqTimeMode <= 1'b1;
			seqOrder <= 3'h7;
		end else if (state == SEQ_IDLE) begin
			seqTimeMode <= timeMode;
			seqOrder <= orderCode;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= SEQ_IDLE;
			pos <= '0;
			msCount <= '0;
			stepDrive <= '0;
		end else if (shutLatch) begin
			state <= SEQ_SHUTDOWN;
			pos <= '0;
			msCount <= '0;
			stepDrive <= '0;
		end else if (!runLevel && upPhase) begin
			// Power-off walks back through the same order
			state <= SEQ_STEP_OFF;
			msCount <= '0;
		end else begin
			if (msTick) begin
				msCount <= msCount + qrps_ms_t'(1);
			end
			unique case (state)
				SEQ_IDLE: begin
					pos <= '0;
					if (runLevel) begin
						state <= SEQ_STEP_ON;
					end
				end
				SEQ_STEP_ON: begin
					stepDrive[curStep] <= 1'b1;
					msCount <= '0;
					state <= seqTimeMode ? SEQ_SOFT_WAIT : SEQ_GOOD_WAIT;
				end
				SEQ_SOFT_WAIT: begin
					if (msTick && msCount == SS_LAST) begin
						msCount <= '0;
						state <= SEQ_STEP_DELAY;
					end
				end
				SEQ_GOOD_WAIT: begin
					msCount <= '0;
					if (railGood[curStep]) begin
						state <= SEQ_STEP_DELAY;
					end
				end
				SEQ_STEP_DELAY: begin
					if (msTick && msCount == stepLast) begin
						msCount <= '0;
						if (pos == LAST_POS) begin
							state <= SEQ_ALL_ON;
						end else begin
							pos <= pos + qrps_pos_t'(1);
							state <= SEQ_STEP_ON;
						end
					end
				end
				SEQ_ALL_ON: begin
					msCount <= '0;
				end
				SEQ_STEP_OFF: begin
					stepDrive[curStep] <= 1'b0;
					msCount <= '0;
					state <= SEQ_OFF_DELAY;
				end
				SEQ_OFF_DELAY: begin
					if (msTick && msCount == stepLast) begin
						msCount <= '0;
						if (pos == '0) begin
							state <= SEQ_IDLE;
						end else begin
							pos <= pos - qrps_pos_t'(1);
							state <= SEQ_STEP_OFF;
						end
					end
				end
				SEQ_SHUTDOWN: begin
					// Latch already cleared by a run edge here
					state <= SEQ_IDLE;
				end
			endcase
		end
	end

	assign step1Drive = stepDrive[0];
	assign step2Drive = stepDrive[1];
	assign step3Drive = stepDrive[2];
	assign step4Drive = stepDrive[3];

	// ********************************************************
	// Status outputs
	// ********************************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sequenceDone <= 1'b0;
		end else begin
			sequenceDone <= (state == SEQ_ALL_ON) && runLevel && !shutLatch;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			globalRailGood <= 1'b0;
		end else begin
			globalRailGood <= (&railGood) & (&startReq) & ~shutLatch & ~hot;
		end
	end

endmodule

//--- tb/qrps_reg_model.sv
// Purpose: Four regulators answering ramp enables with threshold flags.
// Assumes: Ramp time in core clocks.
// Notes: Slow answer is near a real 80 percent point.
`timescale 1ns/1ns
module qrps_reg_model (
	input wire logic core_clk,
	input wire logic [3:0] rampEn,
	input wire logic slow,
	output logic [3:0] atThr
);
	int cnt[4] = '{0, 0, 0, 0};
	initial atThr = 4'h0;
	always @(posedge core_clk) begin
		for (int i = 0; i < 4; i++) begin
			cnt[i] <= rampEn[i] ? cnt[i] + 1 : 0;
			// Flag drops with the enable, never holds a stale high
			atThr[i] <= rampEn[i] && cnt[i] >= (slow ? 30 : 3);
		end
	end
endmodule

//--- tb/qrps_top_properties.sv
// Purpose: Port-level checks of the rail sequencer.
// Assumes: Time base shortened to a few cycles per ms.
// Notes: Bound into qrps_top.
`timescale 1ns/1ns
`include "qrps_cfg.svh"
module qrps_top_properties
	import qrps_pkg::*;
#(
	parameter int CYCLES_PER_MS = 10,
	parameter int SOFT_START_MS = 4
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic seqRun,
	input wire logic overTemp,
	input wire logic delayModeSelect,
	input wire logic rail1StartRequest,
	input wire logic rail2StartRequest,
	input wire logic rail3StartRequest,
	input wire logic rail4StartRequest,
	input wire logic [`QRPS_RAILS-1:0] railAtThreshold,
	input wire logic [`QRPS_RAILS-1:0] railRampEnable,
	input wire logic [`QRPS_RAILS-1:0] railGood,
	input wire logic globalRailGood,
	input wire logic thermalShutdown,
	input wire logic sequenceDone
);
	// Tick phase is free running, so soft start lands within one ms
	localparam int SS_LO = (SOFT_START_MS - 1) * CYCLES_PER_MS - 2;
	localparam int SS_W = CYCLES_PER_MS + 6;
	wire allReq = rail1StartRequest && rail2StartRequest && rail3StartRequest && rail4StartRequest;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	thermal_off_a: assert property (thermalShutdown |=> railRampEnable == 4'h0)
		else $error("ramp enable on during shutdown");
	trip_latch_a: assert property (overTemp [*6] |-> thermalShutdown)
		else $error("over temperature not latched");
	latch_hold_a: assert property ((!seqRun) [*4] ##0 thermalShutdown |=> thermalShutdown)
		else $error("shutdown released without run edge");
	rails_good_a: assert property (railGood != 4'hF ##1 railGood != 4'hF |-> !globalRailGood)
		else $error("global good with a rail not good");
	fault_good_a: assert property (thermalShutdown ##1 thermalShutdown |-> !globalRailGood)
		else $error("global good during fault");
	request_low_a: assert property ((!allReq) [*4] |-> !globalRailGood)
		else $error("global good with a request low");
	ramp_start_a: assert property ($rose(railRampEnable[3]) |-> $past(rail4StartRequest, 3))
		else $error("ramp without its start request");
	soft_start_a: assert property (disable iff (!rst_b || thermalShutdown)
		delayModeSelect && $rose(railRampEnable[0]) |-> ##SS_LO !railGood[0] ##[1:SS_W] railGood[0])
		else $error("soft start length wrong");
	pg_threshold_a: assert property (!delayModeSelect && $rose(railGood[2])
		|-> $past(railAtThreshold[2], 3))
		else $error("rail good before threshold");

	cover property (sequenceDone && delayModeSelect);
	cover property (globalRailGood && !delayModeSelect);
	cover property ($rose(thermalShutdown));
endmodule

bind qrps_top qrps_top_properties #(.CYCLES_PER_MS(CYCLES_PER_MS), .SOFT_START_MS(SOFT_START_MS))
	u_props (.core_clk(core_clk), .rst_b(rst_b), .seqRun(seqRun), .overTemp(overTemp),
	.delayModeSelect(delayModeSelect), .rail1StartRequest(rail1StartRequest),
	.rail2StartRequest(rail2StartRequest), .rail3StartRequest(rail3StartRequest),
	.rail4StartRequest(rail4StartRequest), .railAtThreshold(railAtThreshold),
	.railRampEnable(railRampEnable), .railGood(railGood), .globalRailGood(globalRailGood),
	.thermalShutdown(thermalShutdown), .sequenceDone(sequenceDone));

//--- tb/tb_top.sv
// Purpose: Self-checking bench of the rail sequencer.
// Assumes: Ten core clocks per ms.
// Notes: Board wiring and independent enables are modelled here.
`timescale 1ns/1ns
`include "qrps_cfg.svh"
module tb_top
	import qrps_pkg::*;
;
	logic core_clk = 0, rst_b = 0, mode = 1, run = 0, ot = 0, slow = 0, grp = 0;
	logic [2:0] code = 3'h7;
	logic [3:0] mask = 4'hF, stP = 4'h0, ramp, good, thr;
	wire s1, s2, s3, s4, gg, tsd, done;
	wire [3:0] st = {s4, s3, s2, s1};
	// Grouping: step 1 feeds rails 1 and 2
	wire [3:0] req = mask & (grp ? {s3, s2, s1, s1} : st);
	int nFail = 0, nTests = 0, cyc = 0, grpBad = 0;
	int rq[$], tq[$];
	int ord[8][4] = '{'{4,3,2,1}, '{4,3,1,2}, '{3,4,2,1}, '{3,4,1,2},
		'{2,1,4,3}, '{1,2,4,3}, '{2,1,3,4}, '{1,2,3,4}};

	qrps_top #(.CYCLES_PER_MS(10)) dut (.core_clk(core_clk), .rst_b(rst_b),
		.delayModeSelect(mode), .seqRun(run), .overTemp(ot), .orderSelectBit0(code[0]),
		.orderSelectBit1(code[1]), .orderSelectBit2(code[2]), .rail1StartRequest(req[0]),
		.rail2StartRequest(req[1]), .rail3StartRequest(req[2]), .rail4StartRequest(req[3]),
		.railAtThreshold(thr), .step1Drive(s1), .step2Drive(s2), .step3Drive(s3),
		.step4Drive(s4), .railRampEnable(ramp), .railGood(good), .globalRailGood(gg),
		.thermalShutdown(tsd), .sequenceDone(done));
	qrps_reg_model u_reg (.core_clk(core_clk), .rampEn(ramp), .slow(slow), .atThr(thr));

	always #50 core_clk = ~core_clk;

	// ********
	// Step rise recorder
	// ********
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		stP <= st;
		for (int i = 0; i < 4; i++) begin
			if (st[i] === 1'b1 && stP[i] === 1'b0) begin
				rq.push_back(i + 1);
				tq.push_back(cyc);
			end
		end
		if (grp && ramp[0] !== ramp[1]) begin
			grpBad <= grpBad + 1;
		end
	end

	task chk(string nm, logic [31:0] e, logic [31:0] g);
		nTests++;
		if (g !== e) begin
			nFail++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task rng(string nm, int lo, int hi, int g);
		nTests++;
		if (g < lo || g > hi) begin
			nFail++;
			$display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	// Bounded wait: 0 for done high, 1 for all steps low
	task wt(int w);
		int k;
		k = 0;
		while (k < 3000 && (w ? st !== 4'h0 : done !== 1'b1)) begin
			@(negedge core_clk);
			k++;
		end
		chk("wait", 1, k < 3000);
	endtask

	task up(bit m, int c);
		int lim;
		mode = m;
		code = c[2:0];
		slow = 1'($urandom % 2);
		lim = slow ? 30 : 3;
		rq.delete();
		tq.delete();
		repeat (4) @(negedge core_clk);
		run = 1;
		wt(0);
		repeat (120) @(negedge core_clk);
		for (int i = 0; i < 4; i++) begin
			chk("step", m ? i + 1 : ord[c][i], rq[i]);
			if (i > 0) begin
				rng("gap", m ? 50 : lim + 50, m ? 64 : lim + 74, tq[i] - tq[i - 1]);
			end
		end
		chk("good", 1, gg);
		chk("rail good", 4'hF, good);
	endtask

	task down;
		run = 0;
		wt(1);
		repeat (80) @(negedge core_clk);
		chk("good", 0, gg);
		chk("rail good", 0, good);
	endtask

	task results;
		$display("comparisons %0d mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#5000000;
		nFail++;
		results;
	end

	initial begin
		void'($urandom(87));
		repeat (16) @(negedge core_clk);
		rst_b = 1;
		up(1, 7);
		mask = 4'h7;
		repeat (6) @(negedge core_clk);
		chk("good", 0, gg);
		chk("rail good", 4'h7, good);
		mask = 4'hF;
		down;
		for (int c = 0; c < 8; c++) begin
			up(0, c);
			down;
		end
		grp = 1;
		up(1, 7);
		down;
		grp = 0;
		chk("group", 0, grpBad);
		up(1, 7);
		ot = 1;
		repeat (6) @(negedge core_clk);
		chk("ramp", 0, ramp);
		chk("shut", 1, tsd);
		chk("rail good", 0, good);
		// Chatter around the limit must not release the latch
		ot = 0;
		repeat (3) @(negedge core_clk);
		ot = 1;
		repeat (3) @(negedge core_clk);
		ot = 0;
		repeat (40) @(negedge core_clk);
		chk("off", 0, {ramp, st});
		run = 0;
		repeat (6) @(negedge core_clk);
		run = 1;
		wt(0);
		chk("shut", 0, tsd);
		down;
		results;
	end
endmodule
